// *** common/amsr_pkg.sv ***
package amsr_pkg;

    // Register byte offsets
    localparam logic [7:0] AMSR_CTRL_OFF = 8'h00;
    localparam logic [7:0] AMSR_ADDR_OFF = 8'h04;
    localparam logic [7:0] AMSR_WDLO_OFF = 8'h08;
    localparam logic [7:0] AMSR_WDHI_OFF = 8'h0c;
    localparam logic [7:0] AMSR_RDLO_OFF = 8'h10;
    localparam logic [7:0] AMSR_RDHI_OFF = 8'h14;
    localparam logic [7:0] AMSR_RTIM_OFF = 8'h18;
    localparam logic [7:0] AMSR_WTIM_OFF = 8'h1c;
    localparam logic [7:0] AMSR_CLKC_OFF = 8'h20;

    // Control register fields
    localparam int AMSR_CTRL_START = 0;
    localparam int AMSR_CTRL_WRITE = 1;
    localparam int AMSR_CTRL_BE_LSB = 8;
    localparam int AMSR_CTRL_BUSY = 16;
    localparam int AMSR_CTRL_DONE = 17;

    // Timing register fields, shared by read and write
    localparam int AMSR_SETUP_W = 4;
    localparam int AMSR_STROBE_W = 6;
    localparam int AMSR_HOLD_W = 3;
    localparam int AMSR_SETUP_LSB = 0;
    localparam int AMSR_STROBE_LSB = 4;
    localparam int AMSR_HOLD_LSB = 10;
    localparam int AMSR_CNT_W = 6;

    // Clock config fields
    localparam int AMSR_SRC_LSB = 0;
    localparam int AMSR_DIV_LSB = 4;
    localparam logic [1:0] AMSR_SRC_EXT = 2'h0;
    localparam logic [1:0] AMSR_SRC_CPU4 = 2'h1;
    localparam logic [1:0] AMSR_SRC_CPU6 = 2'h2;
    localparam logic [1:0] AMSR_DIV_1 = 2'h0;
    localparam logic [1:0] AMSR_DIV_2 = 2'h1;
    localparam logic [1:0] AMSR_DIV_4 = 2'h2;
    localparam logic [2:0] AMSR_HALF_CPU4 = 3'h2;
    localparam logic [2:0] AMSR_HALF_CPU6 = 3'h3;

    // Reset values
    localparam logic [12:0] AMSR_TIM_RST = 13'h1fff;
    localparam logic [5:0] AMSR_CLKC_RST = 6'h01;

    // Ready is looked at with this many strobe cycles left
    localparam logic [AMSR_CNT_W-1:0] AMSR_READY_POINT = 6'h02;
    localparam int AMSR_ADDR_W = 20;

    typedef enum logic [1:0] {
        AMSR_IDLE,
        AMSR_SETUP,
        AMSR_STROBE,
        AMSR_HOLD
    } amsr_phase_e;

endpackage

// *** design/amsr_clkgen.sv ***
`timescale 1ns/1ps
`default_nettype none
module amsr_clkgen
    import amsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic external_port_clock_in_i,
    input wire logic [1:0] src_i,
    input wire logic [1:0] div_i,
    output logic full_o,
    output logic divided_o,
    output logic tick_o
);
    logic full_reg, full_next;
    logic div_reg, div_next;
    logic tick_reg, tick_next;
    logic [2:0] cnt_reg, cnt_next;
    logic ph_reg, ph_next;
    logic [2:0] half;

    always_comb begin
        half = (src_i == AMSR_SRC_CPU6) ? AMSR_HALF_CPU6 : AMSR_HALF_CPU4;
        cnt_next = cnt_reg;
        full_next = full_reg;
        if (src_i == AMSR_SRC_EXT) begin
            full_next = external_port_clock_in_i;
            cnt_next = 3'h0;
        end else if (cnt_reg + 3'h1 >= half) begin
            cnt_next = 3'h0;
            full_next = ~full_reg;
        end else begin
            cnt_next = cnt_reg + 3'h1;
        end
        tick_next = full_next & ~full_reg;
        div_next = div_reg;
        ph_next = ph_reg;
        // Divided clock follows the full clock at divide 1, toggles on each of its rising edges at 2 and on every second one at 4: equal halves
        case (div_i)
            AMSR_DIV_2: begin
                if (tick_next) begin
                    div_next = ~div_reg;
                end
            end
            AMSR_DIV_4: begin
                if (tick_next) begin
                    ph_next = ~ph_reg;
                    if (ph_reg) begin
                        div_next = ~div_reg;
                    end
                end
            end
            default: begin
                div_next = full_next;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_reg <= 1'b0;
            div_reg <= 1'b0;
            tick_reg <= 1'b0;
            cnt_reg <= 3'h0;
            ph_reg <= 1'b0;
        end else if (ce_i) begin
            full_reg <= full_next;
            div_reg <= div_next;
            tick_reg <= tick_next;
            cnt_reg <= cnt_next;
            ph_reg <= ph_next;
        end
    end

    assign full_o = full_reg;
    assign divided_o = div_reg;
    assign tick_o = tick_reg;
endmodule
`default_nettype wire

// *** design/amsr_ctrl.sv ***
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Ready input passes a two-flop synchroniser before any use.
// - Ready is looked at only two cycles before the programmed strobe end.
// - While sampled ready is low, strobe grows one memory clock at a time.
// - After ready low, strobe ends two cycles after ready is seen high.
// - Six separate setup, strobe, hold counts for reads and writes.
// - Read selects valid setup periods before and hold periods after strobe.
// - Write selects valid setup periods before and hold periods after strobe.
// - Wide port: select, eight byte enables, address 22:3, 64-bit data.
// - Narrow port: select, two byte enables, address 20:1, 16-bit data.
// - Same sequencer serves 64-bit and 16-bit instances.
// - Port clock from external input, CPU/4 or CPU/6.
// - Divided output clock is port clock over 1, 2 or 4, equal halves.
// - Strobes change only after rising edges of the memory clock.
// - Read data captured at the rising edge of the read strobe.
// - Shared control pins act as output enable and strobes only.
module amsr_ctrl
    import amsr_pkg::*;
#(
    parameter int DATA_W = 64
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic external_port_clock_in_i,
    input wire logic async_ready_in_i,
    input wire logic [DATA_W-1:0] memory_data_i,
    output logic [DATA_W-1:0] memory_data_o,
    output logic memory_data_oe_o,
    output logic chip_select_n_o,
    output logic [DATA_W/8-1:0] byte_lane_enable_n_o,
    output logic [AMSR_ADDR_W-1:0] word_address_o,
    output logic output_enable_n_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic memory_clock_out_full_o,
    output logic memory_clock_out_divided_o
);
    localparam int BE_W = DATA_W / 8;

    // Byte-lane merge of a bus write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus register state
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [AMSR_ADDR_W-1:0] addr_reg, addr_next;
    logic [63:0] wdata_reg, wdata_next;
    logic [63:0] rdata_reg, rdata_next;
    logic [12:0] rtim_reg, rtim_next;
    logic [12:0] wtim_reg, wtim_next;
    logic [5:0] clkc_reg, clkc_next;
    logic [7:0] be_n_reg, be_n_next;
    logic dir_reg, dir_next;
    logic done_reg, done_next;
    logic start_req;

    // Sequencer state
    amsr_phase_e phase_reg, phase_next;
    logic [AMSR_CNT_W-1:0] cnt_reg, cnt_next;
    logic acc_write_reg, acc_write_next;
    logic cs_n_reg, cs_n_next;
    logic oe_n_reg, oe_n_next;
    logic re_n_reg, re_n_next;
    logic we_n_reg, we_n_next;
    logic doe_reg, doe_next;
    logic rdy_meta_reg, rdy_sync_reg;
    logic finish;

    logic tick;
    logic clk_full, clk_div;
    logic wb_req, wb_wr;
    logic [12:0] tim;

    assign wb_req = cyc_i & stb_i & ~ack_reg;
    assign wb_wr = wb_req & we_i;
    assign start_req = wb_wr && adr_i == AMSR_CTRL_OFF && sel_i[0] && dat_i[AMSR_CTRL_START];

    amsr_clkgen u_clkgen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .external_port_clock_in_i(external_port_clock_in_i),
        .src_i(clkc_reg[AMSR_SRC_LSB +: 2]),
        .div_i(clkc_reg[AMSR_DIV_LSB +: 2]),
        .full_o(clk_full),
        .divided_o(clk_div),
        .tick_o(tick)
    );

    // Register file and bus slave
    always_comb begin
        ack_next = wb_req;
        dat_next = dat_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rtim_next = rtim_reg;
        wtim_next = wtim_reg;
        clkc_next = clkc_reg;
        be_n_next = be_n_reg;
        dir_next = dir_reg;
        done_next = done_reg;
        if (wb_wr) begin
            case (adr_i)
                AMSR_CTRL_OFF: begin
                    if (phase_reg == AMSR_IDLE) begin
                        if (sel_i[0]) begin
                            dir_next = dat_i[AMSR_CTRL_WRITE];
                        end
                        if (sel_i[1]) begin
                            be_n_next = ~dat_i[AMSR_CTRL_BE_LSB +: 8];
                        end
                    end
                    if (sel_i[2] && dat_i[AMSR_CTRL_DONE]) begin
                        done_next = 1'b0;
                    end
                end
                AMSR_ADDR_OFF: addr_next = AMSR_ADDR_W'(merge({12'h000, addr_reg}, dat_i,
                                                 sel_i));
                AMSR_WDLO_OFF: wdata_next[31:0] = merge(wdata_reg[31:0], dat_i, sel_i);
                AMSR_WDHI_OFF: wdata_next[63:32] = merge(wdata_reg[63:32], dat_i, sel_i);
                AMSR_RTIM_OFF: rtim_next = 13'(merge({19'h00000, rtim_reg}, dat_i,
                                                 sel_i));
                AMSR_WTIM_OFF: wtim_next = 13'(merge({19'h00000, wtim_reg}, dat_i,
                                                 sel_i));
                AMSR_CLKC_OFF: clkc_next = 6'(merge({26'h0000000, clkc_reg}, dat_i,
                                                 sel_i));
                default: begin
                end
            endcase
        end
        if (wb_req && !we_i) begin
            case (adr_i)
                AMSR_CTRL_OFF: dat_next = {14'h0000, done_reg, phase_reg != AMSR_IDLE,
                                           ~be_n_reg, 6'h00, dir_reg, 1'b0};
                AMSR_ADDR_OFF: dat_next = {12'h000, addr_reg};
                AMSR_WDLO_OFF: dat_next = wdata_reg[31:0];
                AMSR_WDHI_OFF: dat_next = wdata_reg[63:32];
                AMSR_RDLO_OFF: dat_next = rdata_reg[31:0];
                AMSR_RDHI_OFF: dat_next = rdata_reg[63:32];
                AMSR_RTIM_OFF: dat_next = {19'h00000, rtim_reg};
                AMSR_WTIM_OFF: dat_next = {19'h00000, wtim_reg};
                AMSR_CLKC_OFF: dat_next = {26'h0000000, clkc_reg};
                default: dat_next = 32'h00000000;
            endcase
        end
        // Completion beats a clear in the same cycle
        if (finish) begin
            done_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            addr_reg <= '0;
            wdata_reg <= 64'h0000000000000000;
            rtim_reg <= AMSR_TIM_RST;
            wtim_reg <= AMSR_TIM_RST;
            clkc_reg <= AMSR_CLKC_RST;
            be_n_reg <= 8'h00;
            dir_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rtim_reg <= rtim_next;
            wtim_reg <= wtim_next;
            clkc_reg <= clkc_next;
            be_n_reg <= be_n_next;
            dir_reg <= dir_next;
            done_reg <= done_next;
        end
    end

    // Ready synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_meta_reg <= 1'b1;
            rdy_sync_reg <= 1'b1;
        end else if (ce_i) begin
            rdy_meta_reg <= async_ready_in_i;
            rdy_sync_reg <= rdy_meta_reg;
        end
    end

    // Cycle sequencer, advanced only on memory clock rising edges
    always_comb begin
        tim = acc_write_reg ? wtim_reg : rtim_reg;
        phase_next = phase_reg;
        cnt_next = cnt_reg;
        acc_write_next = acc_write_reg;
        cs_n_next = cs_n_reg;
        oe_n_next = oe_n_reg;
        re_n_next = re_n_reg;
        we_n_next = we_n_reg;
        doe_next = doe_reg;
        rdata_next = rdata_reg;
        finish = 1'b0;
        case (phase_reg)
            AMSR_IDLE: begin
                // Start is taken only in a cycle with a clock edge, so setup is whole periods
                if (start_req && tick) begin
                    acc_write_next = dat_i[AMSR_CTRL_WRITE];
                    phase_next = AMSR_SETUP;
                    cnt_next = AMSR_CNT_W'(dat_i[AMSR_CTRL_WRITE] ?
                        wtim_reg[AMSR_SETUP_LSB +: AMSR_SETUP_W] :
                        rtim_reg[AMSR_SETUP_LSB +: AMSR_SETUP_W]);
                    cs_n_next = 1'b0;
                    oe_n_next = dat_i[AMSR_CTRL_WRITE];
                    doe_next = dat_i[AMSR_CTRL_WRITE];
                end
            end
            AMSR_SETUP: begin
                if (tick) begin
                    if (cnt_reg <= AMSR_CNT_W'(1)) begin
                        phase_next = AMSR_STROBE;
                        cnt_next = tim[AMSR_STROBE_LSB +: AMSR_STROBE_W];
                        re_n_next = acc_write_reg;
                        we_n_next = ~acc_write_reg;
                    end else begin
                        cnt_next = cnt_reg - AMSR_CNT_W'(1);
                    end
                end
            end
            AMSR_STROBE: begin
                if (tick) begin
                    if (cnt_reg - AMSR_CNT_W'(1) == AMSR_READY_POINT && !rdy_sync_reg) begin
                        cnt_next = cnt_reg;
                    end else if (cnt_reg <= AMSR_CNT_W'(1)) begin
                        phase_next = AMSR_HOLD;
                        cnt_next = AMSR_CNT_W'(tim[AMSR_HOLD_LSB +: AMSR_HOLD_W]);
                        re_n_next = 1'b1;
                        we_n_next = 1'b1;
                        if (!acc_write_reg) begin
                            rdata_next = 64'(memory_data_i);
                        end
                    end else begin
                        cnt_next = cnt_reg - AMSR_CNT_W'(1);
                    end
                end
            end
            AMSR_HOLD: begin
                if (tick) begin
                    if (cnt_reg <= AMSR_CNT_W'(1)) begin
                        phase_next = AMSR_IDLE;
                        cs_n_next = 1'b1;
                        oe_n_next = 1'b1;
                        doe_next = 1'b0;
                        finish = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - AMSR_CNT_W'(1);
                    end
                end
            end
            default: begin
                phase_next = AMSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= AMSR_IDLE;
            cnt_reg <= '0;
            acc_write_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            re_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            doe_reg <= 1'b0;
            rdata_reg <= 64'h0000000000000000;
        end else if (ce_i) begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            acc_write_reg <= acc_write_next;
            cs_n_reg <= cs_n_next;
            oe_n_reg <= oe_n_next;
            re_n_reg <= re_n_next;
            we_n_reg <= we_n_next;
            doe_reg <= doe_next;
            rdata_reg <= rdata_next;
        end
    end

    // Port-width slices of the register values
    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign memory_data_o = wdata_reg[DATA_W-1:0];
    assign memory_data_oe_o = doe_reg;
    assign chip_select_n_o = cs_n_reg;
    assign byte_lane_enable_n_o = be_n_reg[BE_W-1:0];
    assign word_address_o = addr_reg;
    assign output_enable_n_o = oe_n_reg;
    assign read_strobe_n_o = re_n_reg;
    assign write_strobe_n_o = we_n_reg;
    assign memory_clock_out_full_o = clk_full;
    assign memory_clock_out_divided_o = clk_div;
endmodule
`default_nettype wire

// *** dv/amsr_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module amsr_ctrl_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic chip_select_n_o,
    input wire logic output_enable_n_o,
    input wire logic read_strobe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic memory_data_oe_o,
    input wire logic memory_clock_out_full_o
);
    logic full_reg, rise_reg, rise_next;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_comb begin
        rise_next = memory_clock_out_full_o && !full_reg;
    end
    always_ff @(posedge clk_i) begin
        full_reg <= memory_clock_out_full_o;
        rise_reg <= rise_next;
    end
    a_ack_on_time: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack not one cycle after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_read_selects: assert property (
        !read_strobe_n_o |-> !chip_select_n_o && !output_enable_n_o && !memory_data_oe_o)
        else $error("read strobe without selects");
    a_write_selects: assert property (
        !write_strobe_n_o |-> !chip_select_n_o && output_enable_n_o && memory_data_oe_o)
        else $error("write strobe without selects");
    a_setup_min: assert property (
        $fell(read_strobe_n_o) || $fell(write_strobe_n_o) |-> $past(chip_select_n_o, 4) == 1'b0)
        else $error("setup shorter than one memory clock");
    a_hold_min: assert property (
        $rose(read_strobe_n_o) || $rose(write_strobe_n_o) |-> !chip_select_n_o [*4])
        else $error("hold shorter than one memory clock");
    a_strobe_width: assert property (
        $fell(read_strobe_n_o) |-> !read_strobe_n_o [*4])
        else $error("read strobe shorter than one memory clock");
    a_strobe_on_clock: assert property (
        $changed(read_strobe_n_o) || $changed(write_strobe_n_o)
        |-> ($rose(memory_clock_out_full_o) || rise_reg) or (##1 $rose(memory_clock_out_full_o)))
        else $error("strobe moved away from a memory clock rise");
endmodule
`default_nettype wire

// *** dv/amsr_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module amsr_mem_model
    import amsr_pkg::*;
#(
    parameter int DATA_W = 64
)
(
    input wire logic clk_i,
    input wire logic chip_select_n_i,
    input wire logic output_enable_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [DATA_W/8-1:0] byte_lane_enable_n_i,
    input wire logic [AMSR_ADDR_W-1:0] word_address_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [7:0] stall_i,
    output logic [DATA_W-1:0] data_o,
    output logic ready_o
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last_reg;
    logic [7:0] wait_reg;
    logic idle_reg;
    logic idle;
    initial begin
        foreach (mem[i]) mem[i] = '0;
        last_reg = '0;
        wait_reg = '0;
        idle_reg = 1'b1;
    end
    assign idle = read_strobe_n_i && write_strobe_n_i;
    // Ready held low for stall_i cycles from strobe start
    assign ready_o = (wait_reg == 8'h00);
    // Released bus shows the inverse of the last driven word
    assign data_o = (!chip_select_n_i && !output_enable_n_i) ? mem[word_address_i[3:0]] : ~last_reg;
    always @(posedge clk_i) begin
        idle_reg <= idle;
        if (idle_reg && !idle) wait_reg <= stall_i;
        else if (wait_reg != 8'h00) wait_reg <= wait_reg - 8'h01;
        if (!chip_select_n_i && !output_enable_n_i) last_reg <= mem[word_address_i[3:0]];
        if (!idle_reg && idle && output_enable_n_i && !chip_select_n_i) begin
            for (int b = 0; b < DATA_W/8; b++) begin
                if (!byte_lane_enable_n_i[b]) mem[word_address_i[3:0]][8*b+:8] <= data_i[8*b+:8];
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import amsr_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ext_clk, ready, cs_n, oe_n, re_n, we_n;
    logic data_oe, full, divd, cs_b, re_b, we_b;
    logic [1:0] be_b;
    logic [15:0] wd_b;
    logic [7:0] adr_i, stall, be_n;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [63:0] rd_data, wr_data;
    logic [19:0] addr;
    int fail_count = 0;
    int checks_done = 0;
    int ph, cnt, t_set, t_stb, t_hld, ecnt;

    amsr_ctrl #(.DATA_W(64)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .external_port_clock_in_i(ext_clk), .async_ready_in_i(ready),
        .memory_data_i(rd_data), .memory_data_o(wr_data), .memory_data_oe_o(data_oe),
        .chip_select_n_o(cs_n), .byte_lane_enable_n_o(be_n), .word_address_o(addr),
        .output_enable_n_o(oe_n), .read_strobe_n_o(re_n), .write_strobe_n_o(we_n),
        .memory_clock_out_full_o(full), .memory_clock_out_divided_o(divd));
    amsr_mem_model mem_u (.clk_i(clk_i), .chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
        .read_strobe_n_i(re_n), .write_strobe_n_i(we_n), .byte_lane_enable_n_i(be_n),
        .word_address_i(addr), .data_i(wr_data), .stall_i(stall), .data_o(rd_data),
        .ready_o(ready));
    amsr_ctrl #(.DATA_W(16)) dut_u16 (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(),
        .ack_o(), .external_port_clock_in_i(ext_clk), .async_ready_in_i(ready),
        .memory_data_i(rd_data[15:0]), .memory_data_o(wd_b), .memory_data_oe_o(),
        .chip_select_n_o(cs_b), .byte_lane_enable_n_o(be_b), .word_address_o(),
        .output_enable_n_o(), .read_strobe_n_o(re_b), .write_strobe_n_o(we_b),
        .memory_clock_out_full_o(), .memory_clock_out_divided_o());

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // External port clock, period of ten system clocks
    always @(posedge clk_i) begin
        ecnt <= (ecnt == 4) ? 0 : ecnt + 1;
        if (ecnt == 4) ext_clk <= ~ext_clk;
    end
    // Phase lengths in system clocks
    always @(posedge clk_i) begin
        if (cs_n) begin
            if (ph == 3) t_hld = cnt;
            ph = 0;
            cnt = 0;
        end else if (!re_n || !we_n) begin
            if (ph != 2) begin
                t_set = cnt;
                ph = 2;
                cnt = 0;
            end
            cnt++;
        end else begin
            if (ph == 2) begin
                t_stb = cnt;
                ph = 3;
                cnt = 0;
            end
            cnt++;
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) chk(32'h1, 32'h0);
        @(posedge clk_i);
    endtask
    task automatic acc(input logic w, input logic [12:0] tim, input logic [19:0] a,
                       input logic [63:0] d, input logic [7:0] be, input logic [7:0] st,
                       input int es, input int et, input int eh);
        int n;
        stall <= st;
        wb(1'b1, w ? AMSR_WTIM_OFF : AMSR_RTIM_OFF, {19'h0, tim});
        wb(1'b1, AMSR_ADDR_OFF, {12'h0, a});
        wb(1'b1, AMSR_WDLO_OFF, d[31:0]);
        wb(1'b1, AMSR_WDHI_OFF, d[63:32]);
        n = 0;
        do begin
            wb(1'b1, AMSR_CTRL_OFF, {14'h0, 1'b1, 1'b0, be, 6'h0, w, 1'b1});
            wb(1'b0, AMSR_CTRL_OFF, 32'h0);
            @(posedge clk_i);
            n++;
        end while (q[AMSR_CTRL_BUSY] !== 1'b1 && n < 20);
        chk(32'(q[AMSR_CTRL_BUSY]), 32'h1);
        chk({11'h0, cs_b, re_b, we_b, be_b, wd_b}, {11'h0, cs_n, re_n, we_n, ~be[1:0], d[15:0]});
        chk({12'h0, addr}, {12'h0, a});
        chk({24'h0, be_n}, {24'h0, ~be});
        if (w) chk(wr_data[63:32], d[63:32]);
        do begin
            wb(1'b0, AMSR_CTRL_OFF, 32'h0);
            n++;
        end while (q[AMSR_CTRL_DONE] !== 1'b1 && n < 200);
        chk(32'(q[AMSR_CTRL_DONE]), 32'h1);
        chk(32'(t_set), 32'(es));
        chk(32'(t_stb), 32'(et));
        chk(32'(t_hld), 32'(eh));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    function automatic int span(input logic [63:0] v, input bit hi);
        int r1, n;
        r1 = -1;
        n = 0;
        for (int i = 1; i < 64; i++) begin
            if (v[i] && !v[i-1]) begin
                if (r1 >= 0) return hi ? n : i - r1;
                r1 = i;
            end
            if (r1 >= 0 && v[i]) n++;
        end
        return -1;
    endfunction

    task automatic t_reset;
        chk({29'h0, cs_n, oe_n, data_oe}, 32'h6);
        chk({24'h0, be_n}, 32'h0);
        rdc(AMSR_RTIM_OFF, 32'h1fff);
        rdc(AMSR_WTIM_OFF, 32'h1fff);
        rdc(AMSR_CLKC_OFF, 32'h1);
        wb(1'b1, 8'h24, 32'hffff_ffff);
        rdc(8'h24, 32'h0);
    endtask
    task automatic t_access;
        acc(1'b1, 13'h0432, 20'h5, 64'h0123_4567_89ab_cdef, 8'h0f, 8'h0, 8, 12, 4);
        acc(1'b1, 13'h1c11, 20'h6, 64'hfedc_ba98_7654_3210, 8'hff, 8'h0, 4, 4, 28);
        acc(1'b0, 13'h0841, 20'h5, 64'h0, 8'hff, 8'h0, 4, 16, 8);
        rdc(AMSR_RDLO_OFF, 32'h89ab_cdef);
        rdc(AMSR_RDHI_OFF, 32'h0);
    endtask
    task automatic t_ready;
        // Ready low only before the look point: no stretch
        acc(1'b0, 13'h0461, 20'h6, 64'h0, 8'hff, 8'h8, 4, 24, 4);
        // Ready low across the look point: stretched to two ticks past recovery
        acc(1'b0, 13'h0441, 20'h6, 64'h0, 8'hff, 8'h12, 4, 32, 4);
        rdc(AMSR_RDLO_OFF, 32'h7654_3210);
        rdc(AMSR_RDHI_OFF, 32'hfedc_ba98);
    endtask
    task automatic t_clock(input logic [5:0] cfg, input int pf, input int pd);
        logic [63:0] fv, dv;
        wb(1'b1, AMSR_CLKC_OFF, {26'h0, cfg});
        repeat (40) @(posedge clk_i);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_i);
            fv[i] = full;
            dv[i] = divd;
        end
        chk(32'(span(fv, 0)), 32'(pf));
        chk(32'(span(dv, 0)), 32'(pd));
        chk(32'(span(dv, 1)), 32'(pd / 2));
    endtask

    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h0;
        sel_i = 4'hf;
        dat_i = 32'h0;
        stall = 8'h0;
        ext_clk = 1'b0;
        ecnt = 0;
        ph = 0;
        cnt = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_access();
        t_ready();
        t_clock(6'h12, 6, 12);
        t_clock(6'h21, 4, 16);
        t_clock(6'h00, 10, 10);
        end_sim();
    end
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule
bind amsr_ctrl amsr_ctrl_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .chip_select_n_o(chip_select_n_o), .output_enable_n_o(output_enable_n_o),
    .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
    .memory_data_oe_o(memory_data_oe_o), .memory_clock_out_full_o(memory_clock_out_full_o));
`default_nettype wire
